//--- core/tiop_consts.vh
// Functional notes
// - port widths 1..32, whole port one direction
// - drive pins or sample, optional pin condition
// - every core access completes in one cycle
// - open drain: zero pulls low, one floats
// - data passes serdes plus transfer register
// - 16-bit counter schedules transfer time
// - core reads current counter any time
// - counter captured as timestamp per transfer
// - enabled link disables shared port pins
// - narrower enabled port takes shared pins
// - unshared wide pins stay with wide port
// - port always works at own width
// - six clock blocks, block zero reference
// - other clock blocks have programmable rates
// - clock block may use one-bit port pin
// - pin-fed clock block optionally divides
// - inbound strobe qualifies, outbound strobe leads each slice on the pins by one cycle
// - after reset ports use clock block zero
`ifndef TIOP_CONSTS_VH
`define TIOP_CONSTS_VH

// =========================================================
// register offsets
`define TIOP_CTRL        8'h00
`define TIOP_STATUS      8'h04
`define TIOP_TXDATA      8'h08
`define TIOP_RXDATA      8'h0c
`define TIOP_TIME        8'h10
`define TIOP_COUNT       8'h14
`define TIOP_TSTAMP      8'h18
`define TIOP_COND        8'h1c
`define TIOP_CLKCFG1     8'h20
`define TIOP_CLKCFG5     8'h30
`define TIOP_NCTRL       8'h34
`define TIOP_INT_STATUS  8'h38
`define TIOP_INT_MASK    8'h3c
`define TIOP_LINK        8'h40

// =========================================================
// wide port control fields
`define TIOP_C_EN        0
`define TIOP_C_DIR       1
`define TIOP_C_OD        2
`define TIOP_C_CLK_LO    4
`define TIOP_C_CLK_HI    6
`define TIOP_C_COND_EN   8
`define TIOP_C_TIMED     10
`define TIOP_C_STROBE    11
// narrow port extra fields
`define TIOP_N_OUT       8
`define TIOP_N_IN        12
// clock block fields
`define TIOP_K_SRC_PIN   0
`define TIOP_K_DIV_EN    1
`define TIOP_K_DIV_LO    8
`define TIOP_K_DIV_HI    15
// interrupt bits
`define TIOP_I_RX_READY  0
`define TIOP_I_TX_TAKEN  1
`define TIOP_I_RX_OVER   2
`define TIOP_I_COND_MET  3
`define TIOP_I_BITS      4

// =========================================================
// reset values and timing
`define TIOP_CTRL_RST    32'h0000_0000
`define TIOP_CLKCFG_RST  16'h0000
`define TIOP_NUM_CLKBLK  6
`define TIOP_CB0_MHZ     100
`define TIOP_CNT_W       16

`endif

//--- core/tiop_port.v
`timescale 1ns/1ps
`default_nettype none
`include "tiop_consts.vh"

module tiop_port #(
    parameter WIDTH = 4
) (
    input  wire              mclk_in,
    input  wire              rst_in,
    input  wire              ce_in,
    input  wire              psel_in,
    input  wire              penable_in,
    input  wire              pwrite_in,
    input  wire [7:0]        paddr_in,
    input  wire [31:0]       pwdata_in,
    output reg  [31:0]       prdata_out,
    output reg               pready_out,
    output reg               pslverr_out,
    input  wire [WIDTH-1:0]  pin_in,
    output reg  [WIDTH-1:0]  pin_out,
    output reg  [WIDTH-1:0]  pin_oe_out,
    input  wire              inbound_strobe_in,
    output reg               outbound_strobe_out,
    output reg               irq_out
);

    // slices per word; WIDTH must divide 32
    localparam SHIFTS = 32 / WIDTH;
    localparam NCB    = `TIOP_NUM_CLKBLK;

    // =========================================================
    // pin synchronisers
    reg [WIDTH-1:0] pin_s1;
    reg [WIDTH-1:0] pin_s2;
    reg             clkpin_s3;
    reg             stb_s1;
    reg             stb_s2;

    always @(posedge mclk_in) begin
        if (rst_in) begin
            pin_s1    <= {WIDTH{1'b0}};
            pin_s2    <= {WIDTH{1'b0}};
            clkpin_s3 <= 1'b0;
            stb_s1    <= 1'b0;
            stb_s2    <= 1'b0;
        end else if (ce_in) begin
            pin_s1    <= pin_in;
            pin_s2    <= pin_s1;
            clkpin_s3 <= pin_s2[0];
            stb_s1    <= inbound_strobe_in;
            stb_s2    <= stb_s1;
        end
    end

    // one-bit port pin used as clock source
    // third flop only delays the synced pin
    wire clkpin_edge = pin_s2[0] & ~clkpin_s3;

    // =========================================================
    // registers
    reg [31:0]            ctrl;
    reg [31:0]            nctrl;
    reg [`TIOP_CNT_W-1:0] time_reg;
    reg [WIDTH-1:0]       cond_reg;
    reg                   link_en;
    reg [`TIOP_I_BITS-1:0] int_status;
    reg [`TIOP_I_BITS-1:0] int_mask;
    reg [15:0]            clkcfg [1:NCB-1];

    wire       w_en     = ctrl[`TIOP_C_EN];
    wire       w_out    = ctrl[`TIOP_C_DIR];
    wire       w_od     = ctrl[`TIOP_C_OD];
    wire [2:0] w_clk    = ctrl[`TIOP_C_CLK_HI:`TIOP_C_CLK_LO];

    // narrow port control
    wire       n_en     = nctrl[`TIOP_C_EN];
    wire       n_out    = nctrl[`TIOP_C_DIR];
    wire       n_od     = nctrl[`TIOP_C_OD];
    wire [2:0] n_clk    = nctrl[`TIOP_C_CLK_HI:`TIOP_C_CLK_LO];

    // =========================================================
    // clock blocks
    // block 0 ticks every cycle
    wire [NCB-1:0] tick;
    assign tick[0] = 1'b1;

    genvar g;
    generate
        for (g = 1; g < NCB; g = g + 1) begin : cb
            // one tick per limit+1 events
            reg  [7:0] div_cnt;
            wire       src_pin = clkcfg[g][`TIOP_K_SRC_PIN];
            wire [7:0] div     = clkcfg[g][`TIOP_K_DIV_HI:`TIOP_K_DIV_LO];
            wire [7:0] limit   = (src_pin & ~clkcfg[g][`TIOP_K_DIV_EN]) ? 8'h00 : div;
            wire       evt     = src_pin ? clkpin_edge : 1'b1;
            reg        tk;
            always @(posedge mclk_in) begin
                if (rst_in) begin
                    div_cnt <= 8'h00;
                    tk      <= 1'b0;
                end else if (ce_in) begin
                    tk <= 1'b0;
                    if (evt) begin
                        if (div_cnt >= limit) begin
                            div_cnt <= 8'h00;
                            tk      <= 1'b1;
                        end else begin
                            div_cnt <= div_cnt + 8'h01;
                        end
                    end
                end
            end
            assign tick[g] = tk;
        end
    endgenerate

    // select out of range gives no tick
    wire w_tick = (w_clk < NCB) ? tick[w_clk] : 1'b0;
    wire n_tick = (n_clk < NCB) ? tick[n_clk] : 1'b0;

    // =========================================================
    // wide port datapath
    reg [`TIOP_CNT_W-1:0] w_count;
    reg [`TIOP_CNT_W-1:0] tstamp;
    reg [31:0]            tx_reg;
    reg                   tx_full;
    reg [31:0]            rx_reg;
    reg                   rx_full;
    reg [31:0]            shift;
    reg [5:0]             sh_cnt;
    reg                   cond_hit;
    reg [WIDTH-1:0]       w_drive;

    wire time_ok  = ~ctrl[`TIOP_C_TIMED] | (w_count == time_reg);
    wire cond_now = (pin_s2 == cond_reg);
    wire cond_ok  = ~ctrl[`TIOP_C_COND_EN] | cond_hit | cond_now;
    wire stb_ok   = ~ctrl[`TIOP_C_STROBE] | stb_s2;
    // time match gates the first slot only
    wire slot_ok  = (sh_cnt != 6'd0) | time_ok;
    wire in_step  = w_en & ~w_out & w_tick & cond_ok & stb_ok & slot_ok;
    wire in_last  = in_step & (sh_cnt == SHIFTS - 1);
    wire tx_load  = w_en & w_out & w_tick & (sh_cnt == 6'd0) & tx_full & time_ok;
    wire tx_step  = w_en & w_out & w_tick & (sh_cnt != 6'd0);

    // apb decode
    // writes land only with the answer
    wire        setup  = psel_in & ~penable_in;
    wire        access = psel_in & penable_in;
    wire        wr     = access & pwrite_in & pready_out;
    wire        rd_rx  = setup & ~pwrite_in & (paddr_in == `TIOP_RXDATA);
    wire        wr_tx  = wr & (paddr_in == `TIOP_TXDATA);
    wire        cond_evt = w_en & ~w_out & ctrl[`TIOP_C_COND_EN] & ~cond_hit & cond_now;

    always @(posedge mclk_in) begin
        if (rst_in) begin
            w_count  <= {`TIOP_CNT_W{1'b0}};
            tstamp   <= {`TIOP_CNT_W{1'b0}};
            tx_reg   <= 32'h0000_0000;
            tx_full  <= 1'b0;
            rx_reg   <= 32'h0000_0000;
            rx_full  <= 1'b0;
            shift    <= 32'h0000_0000;
            sh_cnt   <= 6'd0;
            cond_hit <= 1'b0;
            w_drive  <= {WIDTH{1'b0}};
            outbound_strobe_out <= 1'b0;
        end else if (ce_in) begin
            outbound_strobe_out <= 1'b0;
            if (w_tick) begin
                w_count <= w_count + 16'h0001;
            end
            if (cond_evt) begin
                cond_hit <= 1'b1;
            end
            // output: transfer register to serdes, then to pins
            if (wr_tx & ~tx_full) begin
                tx_reg  <= pwdata_in;
                tx_full <= 1'b1;
            end
            if (tx_load) begin
                shift   <= tx_reg;
                sh_cnt  <= SHIFTS[5:0];
                tx_full <= 1'b0;
                tstamp  <= w_count;
            end else if (tx_step) begin
                w_drive <= shift[WIDTH-1:0];
                shift   <= shift >> WIDTH;
                sh_cnt  <= sh_cnt - 6'd1;
                outbound_strobe_out <= 1'b1;
            end
            // input: pins into serdes, then transfer register
            if (rd_rx) begin
                rx_full <= 1'b0;
            end
            if (in_step) begin
                shift <= {pin_s2, shift[31:WIDTH]};
                if (in_last) begin
                    rx_reg   <= {pin_s2, shift[31:WIDTH]};
                    rx_full  <= 1'b1;
                    sh_cnt   <= 6'd0;
                    tstamp   <= w_count;
                    cond_hit <= 1'b0;
                end else begin
                    sh_cnt <= sh_cnt + 6'd1;
                end
            end
        end
    end

    // =========================================================
    // narrow one-bit port on pin 0
    reg [`TIOP_CNT_W-1:0] n_count;
    reg                   n_in;
    reg                   n_drive;

    always @(posedge mclk_in) begin
        if (rst_in) begin
            n_count <= {`TIOP_CNT_W{1'b0}};
            n_in    <= 1'b0;
            n_drive <= 1'b0;
        end else if (ce_in) begin
            if (n_tick) begin
                n_count <= n_count + 16'h0001;
                if (n_en & ~n_out) begin
                    n_in <= pin_s2[0];
                end
                if (n_en & n_out) begin
                    n_drive <= nctrl[`TIOP_N_OUT];
                end
            end
        end
    end

    // =========================================================
    // pin ownership and drive
    // link, then narrow port, then wide port
    integer i;
    reg [WIDTH-1:0] next_pin_out;
    reg [WIDTH-1:0] next_pin_oe;

    always @* begin
        next_pin_out = {WIDTH{1'b0}};
        next_pin_oe  = {WIDTH{1'b0}};
        for (i = 0; i < WIDTH; i = i + 1) begin
            if (link_en) begin
                next_pin_oe[i] = 1'b0;
            end else if (i == 0 && n_en) begin
                if (n_out) begin
                    next_pin_out[i] = n_od ? 1'b0 : n_drive;
                    next_pin_oe[i]  = n_od ? ~n_drive : 1'b1;
                end
            end else if (w_en & w_out) begin
                next_pin_out[i] = w_od ? 1'b0 : w_drive[i];
                next_pin_oe[i]  = w_od ? ~w_drive[i] : 1'b1;
            end
        end
    end

    always @(posedge mclk_in) begin
        if (rst_in) begin
            pin_out    <= {WIDTH{1'b0}};
            pin_oe_out <= {WIDTH{1'b0}};
        end else if (ce_in) begin
            pin_out    <= next_pin_out;
            pin_oe_out <= next_pin_oe;
        end
    end

    // =========================================================
    // interrupt status
    // new word while the last is unread
    wire                    rx_over = in_last & rx_full & ~rd_rx;
    wire [`TIOP_I_BITS-1:0] events = {cond_evt, rx_over, tx_load, in_last};
    wire [`TIOP_I_BITS-1:0] w1c    = (wr && paddr_in == `TIOP_INT_STATUS) ?
                                     pwdata_in[`TIOP_I_BITS-1:0] : {`TIOP_I_BITS{1'b0}};

    always @(posedge mclk_in) begin
        if (rst_in) begin
            int_status <= {`TIOP_I_BITS{1'b0}};
            irq_out    <= 1'b0;
        end else if (ce_in) begin
            // set wins over a same-cycle clear
            int_status <= (int_status & ~w1c) | events;
            irq_out    <= |(int_status & int_mask);
        end
    end

    // =========================================================
    // register writes
    // read-only offsets fall through
    integer k;
    always @(posedge mclk_in) begin
        if (rst_in) begin
            ctrl     <= `TIOP_CTRL_RST;
            nctrl    <= `TIOP_CTRL_RST;
            time_reg <= {`TIOP_CNT_W{1'b0}};
            cond_reg <= {WIDTH{1'b0}};
            link_en  <= 1'b0;
            int_mask <= {`TIOP_I_BITS{1'b0}};
            for (k = 1; k < NCB; k = k + 1) begin
                clkcfg[k] <= `TIOP_CLKCFG_RST;
            end
        end else if (ce_in && wr) begin
            case (paddr_in)
                `TIOP_CTRL:     ctrl     <= pwdata_in;
                `TIOP_NCTRL:    nctrl    <= pwdata_in;
                `TIOP_TIME:     time_reg <= pwdata_in[`TIOP_CNT_W-1:0];
                `TIOP_COND:     cond_reg <= pwdata_in[WIDTH-1:0];
                `TIOP_LINK:     link_en  <= pwdata_in[0];
                `TIOP_INT_MASK: int_mask <= pwdata_in[`TIOP_I_BITS-1:0];
                default: begin
                    for (k = 1; k < NCB; k = k + 1) begin
                        if (paddr_in == `TIOP_CLKCFG1 + 4 * k - 4) begin
                            clkcfg[k] <= pwdata_in[15:0];
                        end
                    end
                end
            endcase
        end
    end

    // =========================================================
    // register reads, zero wait states
    // answer stands until the next setup
    reg [31:0] rd_mux;
    reg        rd_ok;
    integer j;

    always @* begin
        rd_mux = 32'h0000_0000;
        rd_ok  = 1'b1;
        case (paddr_in)
            `TIOP_CTRL:       rd_mux = ctrl;
            `TIOP_STATUS:     rd_mux = {sh_cnt, cond_hit, 23'h0, tx_full, rx_full};
            `TIOP_TXDATA:     rd_mux = tx_reg;
            `TIOP_RXDATA:     rd_mux = rx_reg;
            `TIOP_TIME:       rd_mux = {16'h0000, time_reg};
            `TIOP_COUNT:      rd_mux = {16'h0000, w_count};
            `TIOP_TSTAMP:     rd_mux = {16'h0000, tstamp};
            `TIOP_COND:       rd_mux[WIDTH-1:0] = cond_reg;
            `TIOP_NCTRL:      rd_mux = {n_count, 3'h0, n_in, nctrl[11:0]};
            `TIOP_INT_STATUS: rd_mux[`TIOP_I_BITS-1:0] = int_status;
            `TIOP_INT_MASK:   rd_mux[`TIOP_I_BITS-1:0] = int_mask;
            `TIOP_LINK:       rd_mux[0] = link_en;
            default: begin
                rd_ok = 1'b0;
                for (j = 1; j < NCB; j = j + 1) begin
                    if (paddr_in == `TIOP_CLKCFG1 + 4 * j - 4) begin
                        rd_mux = {16'h0000, clkcfg[j]};
                        rd_ok  = 1'b1;
                    end
                end
            end
        endcase
    end

    always @(posedge mclk_in) begin
        if (rst_in) begin
            prdata_out  <= 32'h0000_0000;
            pready_out  <= 1'b0;
            pslverr_out <= 1'b0;
        end else if (ce_in) begin
            pready_out <= 1'b1;
            if (setup) begin
                prdata_out  <= pwrite_in ? 32'h0000_0000 : rd_mux;
                pslverr_out <= ~rd_ok;
            end
        end
    end

endmodule

`default_nettype wire

//--- tb/timed_io_port_with_clock_blocks_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "tiop_consts.vh"
module timed_io_port_with_clock_blocks_test;
    typedef struct packed {
        logic        we;
        logic [7:0]  a;
        logic [31:0] d;
        logic [31:0] x;
        logic        err;
    } tiop_row_t;

    logic        mclk_in = 1'b0;
    logic        rst_in  = 1'b1;
    logic        ce      = 1'b1;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [7:0]  paddr   = 8'h0;
    logic [31:0] pwdata  = 32'h0;
    logic        send    = 1'b0;
    logic [31:0] word    = 32'h0;
    logic [1:0]  hold    = 2'd1;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [3:0]  dut_po;
    logic [3:0]  oe;
    logic [3:0]  pads;
    logic        istb;
    logic        ostb;
    logic        irq;
    logic [31:0] r;
    logic        e;
    logic [31:0] c0;
    logic [31:0] pw;
    logic [31:0] ow;
    int          n_fail = 0;
    int          checks = 0;

    tiop_row_t rows [13] = '{
        '{1'b0, `TIOP_CTRL, 32'h0, 32'h0, 1'b0},
        '{1'b0, `TIOP_CLKCFG1, 32'h0, 32'h0, 1'b0},
        '{1'b0, `TIOP_CLKCFG5, 32'h0, 32'h0, 1'b0},
        '{1'b1, `TIOP_TIME, 32'h1234, 32'h0, 1'b0},
        '{1'b0, `TIOP_TIME, 32'h0, 32'h1234, 1'b0},
        '{1'b1, `TIOP_CLKCFG1, 32'hff03, 32'h0, 1'b0},
        '{1'b0, `TIOP_CLKCFG1, 32'h0, 32'hff03, 1'b0},
        '{1'b1, `TIOP_COND, 32'ha, 32'h0, 1'b0},
        '{1'b0, `TIOP_COND, 32'h0, 32'ha, 1'b0},
        '{1'b1, `TIOP_TSTAMP, 32'hffff, 32'h0, 1'b0},
        '{1'b0, `TIOP_TSTAMP, 32'h0, 32'h0, 1'b0},
        '{1'b1, 8'h80, 32'h5, 32'h0, 1'b1},
        '{1'b0, 8'h80, 32'h0, 32'h0, 1'b1}
    };

    tiop_port #(.WIDTH(4)) DUT (
        .mclk_in(mclk_in), .rst_in(rst_in), .ce_in(ce), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .pin_in(pads),
        .pin_out(dut_po), .pin_oe_out(oe), .inbound_strobe_in(istb),
        .outbound_strobe_out(ostb), .irq_out(irq)
    );
    tiop_pads u_pads (
        .mclk_in(mclk_in), .drv_in(dut_po), .oe_in(oe), .send_in(send),
        .word_in(word), .hold_in(hold), .pad_out(pads), .strobe_out(istb)
    );

    initial begin
        forever #20 mclk_in = ~mclk_in;
    end

    // ==================================================
    // reporting and bus tasks
    task automatic final_report();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string m);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: %s got %h want %h", $time, m, got, exp);
        end
    endtask

    task automatic chk_flag(input logic got, input logic exp, input string m);
        chk_word({31'h0, got}, {31'h0, exp}, m);
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk_in);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge mclk_in);
        penable <= 1'b1;
        do begin
            @(posedge mclk_in);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            n_fail++;
            final_report();
        end
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic collect();
        int  k;
        int  n;
        logic s;
        k = 0;
        n = 0;
        s = 1'b0;
        while (k < 8 && n < 200) begin
            @(posedge mclk_in);
            #1;
            if (s) begin
                pw[4*k +: 4] = pads;
                ow[4*k +: 4] = oe;
                k++;
            end
            s = ostb;
            n++;
        end
        if (k < 8) begin
            n_fail++;
            final_report();
        end
    endtask

    task automatic send_word(input logic [31:0] w, input logic [1:0] h);
        int n;
        word <= w;
        hold <= h;
        send <= 1'b1;
        @(posedge mclk_in);
        send <= 1'b0;
        n = 0;
        do begin
            apb(1'b0, `TIOP_STATUS, 32'h0);
            n++;
        end while (r[0] !== 1'b1 && n < 40);
        if (n >= 40) begin
            n_fail++;
            final_report();
        end
    endtask

    // ==================================================
    // main sequence
    initial begin
        repeat (8) @(posedge mclk_in);
        rst_in <= 1'b0;
        for (int i = 0; i < 13; i++) begin
            apb(rows[i].we, rows[i].a, rows[i].d);
            if (!rows[i].we)
                chk_word(r, rows[i].x, "register read");
            chk_flag(e, rows[i].err, "error flag");
        end
        apb(1'b1, `TIOP_CTRL, 32'h803);
        apb(1'b0, `TIOP_COUNT, 32'h0);
        c0 = r;
        apb(1'b0, `TIOP_COUNT, 32'h0);
        chk_word(r - c0, 32'h3, "counter step");
        c0 = r;
        ce <= 1'b0;
        repeat (5) @(posedge mclk_in);
        ce <= 1'b1;
        apb(1'b0, `TIOP_COUNT, 32'h0);
        chk_word(r - c0, 32'h3, "count frozen by enable");
        c0 = r;
        apb(1'b1, `TIOP_TXDATA, 32'h8765_4321);
        collect();
        chk_word(pw, 32'h8765_4321, "serial word on pins");
        chk_word(ow, 32'hffff_ffff, "all pins driven");
        apb(1'b0, `TIOP_TSTAMP, 32'h0);
        chk_word(r, (c0 + 32'h5) & 32'hffff, "load timestamp");
        apb(1'b0, `TIOP_COUNT, 32'h0);
        c0 = r + 32'h20;
        apb(1'b1, `TIOP_TIME, c0);
        apb(1'b1, `TIOP_CTRL, 32'hc03);
        apb(1'b1, `TIOP_TXDATA, 32'h1357_9bdf);
        collect();
        chk_word(pw, 32'h1357_9bdf, "timed word on pins");
        apb(1'b0, `TIOP_TSTAMP, 32'h0);
        chk_word(r, c0 & 32'hffff, "timed load stamp");
        apb(1'b1, `TIOP_CTRL, 32'h807);
        apb(1'b1, `TIOP_TXDATA, 32'h0f5a_c3e1);
        collect();
        chk_word(pw, 32'h0f5a_c3e1, "open drain pad levels");
        chk_word(ow, 32'hf0a5_3c1e, "open drain enables");
        apb(1'b1, `TIOP_LINK, 32'h1);
        repeat (3) @(posedge mclk_in);
        #1;
        chk_word({28'h0, oe}, 32'h0, "pins released for link");
        apb(1'b1, `TIOP_LINK, 32'h0);
        apb(1'b1, `TIOP_INT_STATUS, 32'hf);
        apb(1'b1, `TIOP_COND, 32'h5);
        apb(1'b1, `TIOP_CTRL, 32'h901);
        for (int j = 0; j < 2; j++) begin
            apb(1'b1, `TIOP_INT_MASK, (j == 0) ? 32'h1 : 32'h0);
            send_word(32'h7654_3215, 2'(j + 1));
            chk_flag(irq, j == 0, "word ready interrupt");
            apb(1'b0, `TIOP_INT_STATUS, 32'h0);
            chk_flag(r[0], 1'b1, "sticky word event");
            apb(1'b1, `TIOP_INT_STATUS, 32'hf);
            apb(1'b0, `TIOP_RXDATA, 32'h0);
            chk_word(r, 32'h7654_3215, "received word");
            chk_flag(irq, 1'b0, "interrupt cleared");
        end
        apb(1'b1, `TIOP_NCTRL, 32'h103);
        apb(1'b1, `TIOP_CTRL, 32'h803);
        repeat (2) @(posedge mclk_in);
        #1;
        chk_word({24'h0, oe, dut_po}, 32'hf1, "narrow port owns pin 0");
        @(posedge mclk_in);
        rst_in <= 1'b1;
        repeat (2) @(posedge mclk_in);
        rst_in <= 1'b0;
        apb(1'b0, `TIOP_CTRL, 32'h0);
        chk_word(r, 32'h0, "control after reset");
        final_report();
    end
endmodule
`default_nettype wire

//--- tb/tiop_pads.sv
`timescale 1ns/1ps
`default_nettype none
// ==================================================
// attached hardware: pull-ups, word sender
module tiop_pads (
    input  wire logic        mclk_in,
    input  wire logic [3:0]  drv_in,
    input  wire logic [3:0]  oe_in,
    input  wire logic        send_in,
    input  wire logic [31:0] word_in,
    input  wire logic [1:0]  hold_in,
    output logic      [3:0]  pad_out,
    output logic             strobe_out
);
    logic [3:0] ext    = 4'h0;
    logic       ext_oe = 1'b0;
    logic       busy   = 1'b0;
    logic [2:0] idx    = 3'd0;
    logic [1:0] cnt    = 2'd0;
    logic       stb    = 1'b0;

    assign strobe_out = stb;
    always_comb
        for (int i = 0; i < 4; i++)
            pad_out[i] = oe_in[i] ? drv_in[i] : (ext_oe ? ext[i] : 1'b1);

    // slices least significant first, strobe on last hold cycle
    always @(posedge mclk_in) begin
        if (!busy && send_in) begin
            busy   <= 1'b1;
            ext_oe <= 1'b1;
            idx    <= 3'd0;
            cnt    <= 2'd1;
            ext    <= word_in[3:0];
            stb    <= hold_in == 2'd1;
        end else if (busy && cnt == hold_in) begin
            if (idx == 3'd7) begin
                busy   <= 1'b0;
                ext_oe <= 1'b0;
                stb    <= 1'b0;
            end else begin
                idx <= idx + 3'd1;
                cnt <= 2'd1;
                ext <= word_in[4*idx+4 +: 4];
                stb <= hold_in == 2'd1;
            end
        end else if (busy) begin
            cnt <= cnt + 2'd1;
            stb <= cnt + 2'd1 == hold_in;
        end
    end
endmodule
`default_nettype wire

//--- tb/tiop_port_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "tiop_consts.vh"
// ==================================================
// port bus and pin checks
module tiop_port_checker #(
    parameter WIDTH = 4
) (
    input wire logic             mclk_in,
    input wire logic             rst_in,
    input wire logic             ce_in,
    input wire logic             psel_in,
    input wire logic             penable_in,
    input wire logic             pwrite_in,
    input wire logic [7:0]       paddr_in,
    input wire logic [31:0]      pwdata_in,
    input wire logic [31:0]      prdata_out,
    input wire logic             pready_out,
    input wire logic             pslverr_out,
    input wire logic [WIDTH-1:0] pin_out,
    input wire logic [WIDTH-1:0] pin_oe_out
);
    wire logic       setup = psel_in && !penable_in && ce_in;
    wire logic       wr_done = psel_in && penable_in && pwrite_in && pready_out && ce_in;
    wire logic       link_wr = wr_done && paddr_in == `TIOP_LINK;
    logic            od_q;
    logic [1:0]      age;

    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);

    // cycles since last write, saturating
    always @(posedge mclk_in) begin
        if (rst_in) begin
            od_q <= 1'b0;
            age  <= 2'd0;
        end else if (wr_done) begin
            age <= 2'd0;
            if (paddr_in == `TIOP_CTRL)
                od_q <= pwdata_in[`TIOP_C_OD];
        end else if (age != 2'd3)
            age <= age + 2'd1;
    end

    sequence s_link_set;
        link_wr && pwdata_in[0];
    endsequence

    chk_reset_quiet: assert property (disable iff (1'b0)
        rst_in && ce_in |=> !pready_out && pin_oe_out == '0)
        else $error("outputs active during reset");
    chk_zero_wait: assert property (setup |=> pready_out)
        else $error("no answer one cycle after setup");
    chk_unmapped_err: assert property (
        setup && paddr_in > 8'h43 |=> pslverr_out && prdata_out == 32'h0)
        else $error("unmapped access not refused");
    chk_mapped_ok: assert property (
        setup && paddr_in <= 8'h40 && paddr_in[1:0] == 2'd0 |=> !pslverr_out)
        else $error("mapped access refused");
    chk_write_rdata: assert property (setup && pwrite_in |=> prdata_out == 32'h0)
        else $error("read data not zero on write");
    chk_answer_hold: assert property (
        !setup |=> $stable(prdata_out) && $stable(pslverr_out))
        else $error("answer changed without setup");
    chk_od_low: assert property (od_q && age == 2'd3 |-> pin_out == '0)
        else $error("open drain pin driven high");
    chk_link_quiet: assert property (
        s_link_set ##1 (!link_wr) [*2] |=> pin_oe_out == '0)
        else $error("pins driven while link enabled");
endmodule

bind tiop_port tiop_port_checker #(.WIDTH(WIDTH)) u_chk (
    .mclk_in    (mclk_in),
    .rst_in     (rst_in),
    .ce_in      (ce_in),
    .psel_in    (psel_in),
    .penable_in (penable_in),
    .pwrite_in  (pwrite_in),
    .paddr_in   (paddr_in),
    .pwdata_in  (pwdata_in),
    .prdata_out (prdata_out),
    .pready_out (pready_out),
    .pslverr_out(pslverr_out),
    .pin_out    (pin_out),
    .pin_oe_out (pin_oe_out)
);
`default_nettype wire
